// ===== hdl/chsd_pkg.sv
// Purpose: shared constants and types for the card host strobe decoder
// Assumes: one system clock, strobes arrive asynchronously from the host
// Notes:   mode encoding is the interface mode chosen by the card configuration
package chsd_pkg;

	typedef enum logic [1:0]
	{
		CHSD_MODE_MEMORY,
		CHSD_MODE_IO,
		CHSD_MODE_IDE
	} chsd_mode_type;

	localparam int          CHSD_DATA_W     = 16;
	localparam int          CHSD_ADDR_W     = 4;
	localparam int          CHSD_SYNC_DEPTH = 2;
	localparam logic        CHSD_STROBE_RST = 1'b1;
	localparam logic        CHSD_ROLE_RST   = 1'b1;
	localparam logic [15:0] CHSD_DATA_RST   = 16'h0000;
	localparam logic [3:0]  CHSD_ADDR_RST   = 4'h0;

	typedef struct packed
	{
		logic [CHSD_ADDR_W-1:0] addr;
		logic [CHSD_DATA_W-1:0] data;
	} chsd_wr_type;

	typedef struct packed
	{
		logic card_info; // read of card info structure or configuration space
		logic storage;   // read of storage data
	} chsd_rd_type;

endpackage

// ===== hdl/chsd_sync.sv
// Purpose: two flip-flop synchroniser for one asynchronous level
// Assumes: input is from outside the clock domain
// Notes:   first stage is read only by the second stage
module chsd_sync
	import chsd_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// level in and out
	input  wire logic d,
	output logic      q
);

	logic meta_r;
	logic q_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= RST_VAL;
			q_r    <= RST_VAL;
		end
		else
		begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end

	assign q = q_r;

endmodule

// ===== hdl/chsd_top.sv
// Purpose: decode host write, output-enable and role strobes of the parallel host port
// Assumes: CLK_SYS 20 MHz; strobes, role select and bus are asynchronous host pins
// Notes:   address and data are sampled from the synchronised bus while the strobe is low and written out at its rise
module chsd_top
	import chsd_pkg::*;
#(
	parameter int DATA_W = CHSD_DATA_W,
	parameter int ADDR_W = CHSD_ADDR_W
)
(
	// clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	// mode and burst state from the card controller
	input  wire chsd_mode_type     MODE,
	input  wire logic              UDMA_ACTIVE,
	// host pins
	input  wire logic              IO_WRITE_STROBE_N,
	input  wire logic              OUTPUT_ENABLE_N,
	input  wire logic              DRIVE_ROLE_SELECT_N,
	input  wire logic              REG_SPACE_N,
	input  wire logic [ADDR_W-1:0] HOST_ADDR,
	input  wire logic [DATA_W-1:0] HOST_DATA_IN,
	// register write port
	output logic                   REG_WR,
	output logic [ADDR_W-1:0]      REG_WR_ADDR,
	output logic [DATA_W-1:0]      REG_WR_DATA,
	// burst stop
	output logic                   UDMA_STOP,
	// read strobe decode
	output logic                   RD_STORAGE,
	output logic                   RD_CARD_INFO,
	input  wire logic [DATA_W-1:0] RD_DATA,
	output logic [DATA_W-1:0]      HOST_DATA_OUT,
	output logic                   HOST_DATA_OE,
	// drive role
	output logic                   IS_PRIMARY,
	output logic                   IS_SECONDARY
);

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	logic              iow_s;
	logic              oe_s;
	logic              role_s;
	logic              reg_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;

	chsd_sync #(.RST_VAL(CHSD_STROBE_RST)) u_sync_iow
	(
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.d     (IO_WRITE_STROBE_N),
		.q     (iow_s)
	);

	chsd_sync #(.RST_VAL(CHSD_STROBE_RST)) u_sync_oe
	(
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.d     (OUTPUT_ENABLE_N),
		.q     (oe_s)
	);

	chsd_sync #(.RST_VAL(CHSD_ROLE_RST)) u_sync_role
	(
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.d     (DRIVE_ROLE_SELECT_N),
		.q     (role_s)
	);

	chsd_sync #(.RST_VAL(CHSD_STROBE_RST)) u_sync_reg
	(
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.d     (REG_SPACE_N),
		.q     (reg_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < ADDR_W; gi++)
		begin : g_addr
			chsd_sync #(.RST_VAL(1'b0)) u_sync
			(
				.clk   (CLK_SYS),
				.rst_n (RST_N),
				.d     (HOST_ADDR[gi]),
				.q     (addr_s[gi])
			);
		end
		for (gi = 0; gi < DATA_W; gi++)
		begin : g_data
			chsd_sync #(.RST_VAL(1'b0)) u_sync
			(
				.clk   (CLK_SYS),
				.rst_n (RST_N),
				.d     (HOST_DATA_IN[gi]),
				.q     (data_s[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// edge detection
	// ------------------------------------------------------------
	logic              iow_d_r;
	logic [ADDR_W-1:0] addr_hold_r;
	logic [DATA_W-1:0] data_hold_r;
	logic              iow_rise;
	logic              iow_fall;

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			iow_d_r <= CHSD_STROBE_RST;
		else
			iow_d_r <= iow_s;
	end

	// bus sampled while the strobe is still low, so it is valid at the rise
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			addr_hold_r <= '0;
			data_hold_r <= '0;
		end
		else if (!iow_s)
		begin
			addr_hold_r <= addr_s;
			data_hold_r <= data_s;
		end
	end

	assign iow_rise = iow_s && !iow_d_r;
	assign iow_fall = !iow_s && iow_d_r;

	// ------------------------------------------------------------
	// register write
	// ------------------------------------------------------------
	logic              wr_en;
	logic              reg_wr_r;
	logic [ADDR_W-1:0] reg_wr_addr_r;
	logic [DATA_W-1:0] reg_wr_data_r;

	always_comb
	begin
		case (MODE)
			CHSD_MODE_IO:     wr_en = 1'b1;
			CHSD_MODE_IDE:    wr_en = !UDMA_ACTIVE;
			CHSD_MODE_MEMORY: wr_en = 1'b0;
			default:          wr_en = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			reg_wr_r <= 1'b0;
		else
			reg_wr_r <= iow_rise && wr_en;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			reg_wr_addr_r <= CHSD_ADDR_RST[ADDR_W-1:0];
			reg_wr_data_r <= CHSD_DATA_RST[DATA_W-1:0];
		end
		else if (iow_rise && wr_en)
		begin
			reg_wr_addr_r <= addr_hold_r;
			reg_wr_data_r <= data_hold_r;
		end
	end

	// ------------------------------------------------------------
	// burst stop
	// ------------------------------------------------------------
	logic stop_r;

	// strobe is high on burst entry, so a fall is the stop request
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			stop_r <= 1'b0;
		else
			stop_r <= (MODE == CHSD_MODE_IDE) && UDMA_ACTIVE && iow_fall;
	end

	// ------------------------------------------------------------
	// read strobe decode
	// ------------------------------------------------------------
	chsd_rd_type rd_nxt;
	chsd_rd_type rd_r;
	logic [DATA_W-1:0] dout_r;

	always_comb
	begin
		rd_nxt = '0;
		case (MODE)
			CHSD_MODE_MEMORY:
			begin
				rd_nxt.storage   = !oe_s && reg_s;
				rd_nxt.card_info = !oe_s && !reg_s;
			end
			CHSD_MODE_IO:
				rd_nxt.card_info = !oe_s && !reg_s;
			default:
				rd_nxt = '0;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			rd_r <= '0;
		else
			rd_r <= rd_nxt;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			dout_r <= CHSD_DATA_RST[DATA_W-1:0];
		else if (rd_nxt.storage || rd_nxt.card_info)
			dout_r <= RD_DATA;
	end

	// ------------------------------------------------------------
	// drive role
	// ------------------------------------------------------------
	logic primary_r;

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			primary_r <= 1'b0;
		else
			primary_r <= !role_s;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign REG_WR        = reg_wr_r;
	assign REG_WR_ADDR   = reg_wr_addr_r;
	assign REG_WR_DATA   = reg_wr_data_r;
	assign UDMA_STOP     = stop_r;
	assign RD_STORAGE    = rd_r.storage;
	assign RD_CARD_INFO  = rd_r.card_info;
	assign HOST_DATA_OUT = dout_r;
	assign HOST_DATA_OE  = rd_r.storage || rd_r.card_info;
	assign IS_PRIMARY    = (MODE == CHSD_MODE_IDE) && primary_r;
	assign IS_SECONDARY  = (MODE == CHSD_MODE_IDE) && !primary_r;

endmodule

// ===== tb/card_host_strobe_decode_tb_top.sv
// Purpose: self-checking bench for chsd_top
// Assumes: host model drives pins at the falling edge
// Notes:   writes and stops are noted in one queue
module card_host_strobe_decode_tb_top;
	import chsd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic udma = 1'b0;
	logic role_n = 1'b1;
	logic [15:0] rd_data = 16'h0;
	chsd_mode_type mode = CHSD_MODE_IO;
	wire iow_n, oe_n, sp_n, reg_wr, stop, rd_st, rd_ci, hoe, prim, sec;
	wire [3:0] haddr, waddr;
	wire [15:0] hdin, wdata, hdo;
	logic [20:0] exp_q[$];
	logic [31:0] r;
	int seed = 1925;
	int fails = 0;
	int num_checks = 0;
	always #25 clk_sys = ~clk_sys;
	chsd_host_model host (.clk(clk_sys), .iow_n(iow_n), .oe_n(oe_n), .space_n(sp_n),
		.addr(haddr), .data(hdin));
	chsd_top uut (.CLK_SYS(clk_sys), .RST_N(rst_n), .MODE(mode), .UDMA_ACTIVE(udma),
		.IO_WRITE_STROBE_N(iow_n), .OUTPUT_ENABLE_N(oe_n), .DRIVE_ROLE_SELECT_N(role_n),
		.REG_SPACE_N(sp_n), .HOST_ADDR(haddr), .HOST_DATA_IN(hdin), .REG_WR(reg_wr),
		.REG_WR_ADDR(waddr), .REG_WR_DATA(wdata), .UDMA_STOP(stop), .RD_STORAGE(rd_st),
		.RD_CARD_INFO(rd_ci), .RD_DATA(rd_data), .HOST_DATA_OUT(hdo), .HOST_DATA_OE(hoe),
		.IS_PRIMARY(prim), .IS_SECONDARY(sec));
	task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----
	// result watcher
	// ----
	// outputs are looked at half a cycle after the edge that launches them
	always @(negedge clk_sys)
		if (reg_wr === 1'b1 || stop === 1'b1)
			chk("wr_or_stop",
				exp_q.size() ? exp_q.pop_front() : 21'h1fffff,
				stop === 1'b1 ? 21'h100000 : {1'b0, waddr, wdata});
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		fails++;
		report_and_stop();
	end
	// ----
	// main sequence
	// ----
	initial
	begin
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		for (int i = 0; i < 6; i++)
		begin
			mode = (i < 3) ? CHSD_MODE_IO : (i == 3) ? CHSD_MODE_MEMORY : CHSD_MODE_IDE;
			udma = (i == 5);
			r = $random(seed);
			if (mode != CHSD_MODE_MEMORY)
				exp_q.push_back(udma ? 21'h100000 : {1'b0, r[19:0]});
			host.wr(r[19:0], i % 2);
			repeat (4) @(negedge clk_sys);
		end
		udma = 1'b0;
		mode = CHSD_MODE_IDE;
		for (int i = 0; i < 3; i++)
		begin
			role_n = i[0];
			if (i == 2)
				mode = CHSD_MODE_IO;
			repeat (6) @(negedge clk_sys);
			chk("role", {19'h0, i == 0, i == 1}, {19'h0, prim, sec});
		end
		for (int i = 0; i < 5; i++)
		begin
			mode = (i < 2) ? CHSD_MODE_MEMORY : (i < 4) ? CHSD_MODE_IO : CHSD_MODE_IDE;
			r = $random(seed);
			rd_data = r[15:0];
			fork
				host.rd(i[0] == 1'b0 && i != 4);
				begin
					repeat (6) @(negedge clk_sys);
					chk("read",
						{2'b0, i == 0, i == 1 || i == 3, i == 0 || i == 1 || i == 3,
						(i == 0 || i == 1 || i == 3) ? rd_data : 16'h0},
						{2'b0, rd_st, rd_ci, hoe, hoe ? hdo : 16'h0});
				end
			join
		end
		for (int k = 0; k < 50 && exp_q.size() > 0; k++)
			@(negedge clk_sys);
		chk("pending", 21'h0, 21'(exp_q.size()));
		report_and_stop();
	end
endmodule

// ===== tb/chsd_host_model.sv
// Purpose: host controller model driving the strobe pins
// Assumes: called at a falling clock edge
// Notes:   bus is inverted once the strobe has been high a while
module chsd_host_model
	import chsd_pkg::*;
(
	// clock
	input wire logic               clk,
	// host pins
	output logic                   iow_n,
	output logic                   oe_n,
	output logic                   space_n,
	output logic [CHSD_ADDR_W-1:0] addr,
	output logic [CHSD_DATA_W-1:0] data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		iow_n = 1'b1;
		oe_n = 1'b1;
		space_n = 1'b1;
		{addr, data} = 20'h0;
	end
	task automatic wr(input chsd_wr_type w, input int slow);
		{addr, data} = w;
		repeat (3 + slow) @(negedge clk);
		iow_n = 1'b0;
		repeat (3 + slow) @(negedge clk);
		iow_n = 1'b1;
		repeat (3) @(negedge clk);
		{addr, data} = ~w;
	endtask
	task automatic rd(input logic sp);
		space_n = sp;
		@(negedge clk);
		oe_n = 1'b0;
		repeat (7) @(negedge clk);
		oe_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
endmodule

// ===== tb/chsd_top_asserts.sv
// Purpose: port checks for chsd_top
// Assumes: MODE and UDMA_ACTIVE stay steady around each strobe
// Notes:   bound to the top at the foot of this file
module chsd_top_asserts
	import chsd_pkg::*;
(
	// clock and reset
	input wire logic          CLK_SYS,
	input wire logic          RST_N,
	// controls and host pins
	input wire chsd_mode_type MODE,
	input wire logic          UDMA_ACTIVE,
	input wire logic          IO_WRITE_STROBE_N,
	input wire logic          OUTPUT_ENABLE_N,
	input wire logic          DRIVE_ROLE_SELECT_N,
	input wire logic          REG_SPACE_N,
	// decoded outputs
	input wire logic          REG_WR,
	input wire logic          UDMA_STOP,
	input wire logic          RD_STORAGE,
	input wire logic          RD_CARD_INFO,
	input wire logic          HOST_DATA_OE,
	input wire logic          IS_PRIMARY,
	input wire logic          IS_SECONDARY
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// ----
	// strobe checks
	// ----
	property p_wr_mem; REG_WR |-> MODE != CHSD_MODE_MEMORY; endproperty
	a_wr_mem: assert property (p_wr_mem) else $error("write in memory mode");
	property p_wr_edge; REG_WR |-> $past(IO_WRITE_STROBE_N, 2) && !$past(IO_WRITE_STROBE_N, 6); endproperty
	a_wr_edge: assert property (p_wr_edge) else $error("write not on rise");
	property p_wr_io;
		$rose(IO_WRITE_STROBE_N) && (MODE == CHSD_MODE_IO || (MODE == CHSD_MODE_IDE && !UDMA_ACTIVE))
			|-> ##[2:4] REG_WR;
	endproperty
	a_wr_io: assert property (p_wr_io) else $error("no write after rise");
	property p_stop_req;
		$fell(IO_WRITE_STROBE_N) && MODE == CHSD_MODE_IDE && UDMA_ACTIVE |-> ##[2:4] UDMA_STOP;
	endproperty
	a_stop_req: assert property (p_stop_req) else $error("no burst stop");
	property p_wr_udma; REG_WR |-> !(MODE == CHSD_MODE_IDE && UDMA_ACTIVE); endproperty
	a_wr_udma: assert property (p_wr_udma) else $error("write during burst");
	property p_stop; UDMA_STOP |-> MODE == CHSD_MODE_IDE && UDMA_ACTIVE && !$past(IO_WRITE_STROBE_N, 3); endproperty
	a_stop: assert property (p_stop) else $error("bad burst stop");
	property p_role_p; (MODE == CHSD_MODE_IDE && !DRIVE_ROLE_SELECT_N)[*5] |-> IS_PRIMARY && !IS_SECONDARY; endproperty
	a_role_p: assert property (p_role_p) else $error("not primary");
	property p_role_s; (MODE == CHSD_MODE_IDE && DRIVE_ROLE_SELECT_N)[*5] |-> IS_SECONDARY && !IS_PRIMARY; endproperty
	a_role_s: assert property (p_role_s) else $error("not secondary");
	property p_role_off; MODE != CHSD_MODE_IDE |-> !IS_PRIMARY && !IS_SECONDARY; endproperty
	a_role_off: assert property (p_role_off) else $error("role outside ide");
	property p_rd_mem; (MODE == CHSD_MODE_MEMORY && !OUTPUT_ENABLE_N && REG_SPACE_N)[*5] |-> RD_STORAGE && HOST_DATA_OE; endproperty
	a_rd_mem: assert property (p_rd_mem) else $error("no storage read");
	property p_rd_io; RD_STORAGE |-> MODE == CHSD_MODE_MEMORY; endproperty
	a_rd_io: assert property (p_rd_io) else $error("storage read off mode");
	c_wr: cover property (REG_WR);
	c_stop: cover property (UDMA_STOP);
	c_info: cover property (RD_CARD_INFO);
endmodule

bind chsd_top chsd_top_asserts u_asrt (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .MODE(MODE),
	.UDMA_ACTIVE(UDMA_ACTIVE), .IO_WRITE_STROBE_N(IO_WRITE_STROBE_N),
	.OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .DRIVE_ROLE_SELECT_N(DRIVE_ROLE_SELECT_N),
	.REG_SPACE_N(REG_SPACE_N), .REG_WR(REG_WR), .UDMA_STOP(UDMA_STOP), .RD_STORAGE(RD_STORAGE),
	.RD_CARD_INFO(RD_CARD_INFO), .HOST_DATA_OE(HOST_DATA_OE), .IS_PRIMARY(IS_PRIMARY),
	.IS_SECONDARY(IS_SECONDARY));
